// ==== ovs_defs.svh ====
`ifndef OVS_DEFS_SVH
`define OVS_DEFS_SVH

// ============================================================
// Register byte offsets
`define OVS_OFS_INT_EN_RISE   5'h00
`define OVS_OFS_INT_EN_FALL   5'h04
`define OVS_OFS_INT_STATUS    5'h08
`define OVS_OFS_OTG_CTRL      5'h0C
`define OVS_OFS_VBUS_IND      5'h10
`define OVS_OFS_IO_PWR        5'h14
`define OVS_OFS_CARKIT_CTRL   5'h18
`define OVS_OFS_PIN_STATUS    5'h1C

// ============================================================
// Field positions
`define OVS_BIT_VBUS_VALID    1
`define OVS_BIT_SESS_VALID    2
`define OVS_BIT_DISCHARGE     3
`define OVS_BIT_CHARGE        4
`define OVS_BIT_USE_EXT       0
`define OVS_BIT_PASS_THRU     1
`define OVS_BIT_COMPLEMENT    2
`define OVS_BIT_DP_PULLUP     0
`define OVS_BIT_DM_PULLUP     1
`define OVS_BIT_LVL_LO        2
`define OVS_BIT_LVL_HI        3
`define OVS_BIT_UART_MODE     4
`define OVS_BIT_SPK_LEFT      0
`define OVS_BIT_SPK_RIGHT     1
`define OVS_BIT_MIC           2

// ============================================================
// Reset values
`define OVS_RST_BYTE          8'h00
`define OVS_RST_LEVEL         2'h0
`define OVS_EXT_INDICATOR     1'b1

`endif

// ==== ovs_pkg.sv ====
package ovs_pkg;

    // ========================================================
    // Bus response codes
    typedef enum logic [1:0] {
        OVS_RESP_OKAY   = 2'b00,
        OVS_RESP_SLVERR = 2'b10
    } ovs_resp_type;

    // Byte-wide register content
    typedef logic [7:0] ovs_byte_type;

endpackage

// ==== ovs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Two-stage synchroniser, one pair of flops per bit
module ovs_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Asynchronous levels in, synchronous levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // Refuse a width the generate loop cannot serve
    if (WIDTH < 1) begin : g_bad_width
        $error("ovs_sync: WIDTH must be at least 1");
    end

    // ========================================================
    // Per-bit chains; first flop feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_ff;  // First stage, metastable
        logic hold_ff;  // Second stage, safe to use
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                meta_ff <= 1'b0;
                hold_ff <= 1'b0;
            end else begin
                meta_ff <= async_in[i];
                hold_ff <= meta_ff;
            end
        end
        assign sync_out[i] = hold_ff;
    end

endmodule

`default_nettype wire

// ==== ovs_ctrl.sv ====
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ovs_defs.svh"

module ovs_ctrl #(
    parameter int ADDR_W = 5
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output ovs_pkg::ovs_resp_type     s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output ovs_pkg::ovs_resp_type     s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Analog comparator and pin levels (asynchronous)
    input  wire logic                 bus_voltage_valid_comparator,
    input  wire logic                 session_valid_comparator,
    input  wire logic                 chip_reset_n,
    input  wire logic                 core_supply_present,
    // Vbus monitor outputs
    output logic                      vbus_comparator_enable,
    output logic                      rxcmd_vbus_valid,
    output logic                      bus_discharge_enable,
    output logic                      bus_charge_enable,
    // UART mode outputs
    output logic                      uart_regulator_active,
    output logic [1:0]                uart_regulator_level,
    output logic                      linestate_drive_enable,
    // Charger detect and audio outputs
    output logic                      dplus_charger_pullup_enable,
    output logic                      dminus_charger_pullup_enable,
    output logic                      dplus_audio_switch_on,
    output logic                      dminus_audio_switch_on,
    output logic                      se_receiver_enable
);
    import ovs_pkg::*;

    // Offsets below need five address bits
    if (ADDR_W < 5) begin : g_bad_addr
        $error("ovs_ctrl: ADDR_W must be at least 5");
    end

    // ========================================================
    // Pin synchronisation
    logic [3:0] pin_sync;       // Synchronised pin levels
    logic       vbus_raw;       // Comparator, synchronised
    logic       sess_raw;       // Session valid, synchronised
    logic       rst_pin;        // Reset pin, synchronised
    logic       core_ok;        // Core supply, synchronised

    ovs_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({core_supply_present, chip_reset_n,
                    session_valid_comparator,
                    bus_voltage_valid_comparator}),
        .sync_out (pin_sync)
    );
    assign vbus_raw = pin_sync[0];
    assign sess_raw = pin_sync[1];
    assign rst_pin  = pin_sync[2];
    assign core_ok  = pin_sync[3];

    // ========================================================
    // Register storage
    ovs_byte_type en_rise_ff;   // Rising-edge enables
    ovs_byte_type en_fall_ff;   // Falling-edge enables
    ovs_byte_type otg_ff;       // OTG control
    ovs_byte_type ind_ff;       // Vbus indicator select
    ovs_byte_type iopwr_ff;     // IO and power management
    ovs_byte_type carkit_ff;    // Carkit control

    // ========================================================
    // Write channel: address and data taken in either order
    logic              aw_held_ff;  // Address captured
    logic              w_held_ff;   // Data captured
    logic [ADDR_W-1:0] waddr_ff;    // Captured address
    logic [7:0]        wdata_ff;    // Captured low byte
    logic              wstrb_ff;    // Low lane strobe
    logic              bvalid_ff;   // Response pending
    ovs_resp_type      bresp_ff;    // Response code
    logic              wr_fire;     // Write commits this edge
    logic              wr_known;    // Address is writable

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;

    // Writable offsets; status words are read only
    always_comb begin
        case (waddr_ff[4:0])
            `OVS_OFS_INT_EN_RISE, `OVS_OFS_INT_EN_FALL,
            `OVS_OFS_OTG_CTRL, `OVS_OFS_VBUS_IND,
            `OVS_OFS_IO_PWR, `OVS_OFS_CARKIT_CTRL: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // Capture address and data, then answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            waddr_ff   <= '0;
            wdata_ff   <= `OVS_RST_BYTE;
            wstrb_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= OVS_RESP_OKAY;
        end else begin
            // Address handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                waddr_ff   <= s_axi_awaddr;
            end
            // Data handshake, only low byte carries fields
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata[7:0];
                wstrb_ff  <= s_axi_wstrb[0];
            end
            // Both present: commit and respond next cycle
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_known ? OVS_RESP_OKAY
                                       : OVS_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ========================================================
    // Register updates; all clear on reset
    // Indicator select resets off, internal source
    // Audio enables reset cleared
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_rise_ff <= `OVS_RST_BYTE;
            en_fall_ff <= `OVS_RST_BYTE;
            otg_ff     <= `OVS_RST_BYTE;
            ind_ff     <= `OVS_RST_BYTE;
            iopwr_ff   <= `OVS_RST_BYTE;
            carkit_ff  <= `OVS_RST_BYTE;
        end else if (wr_fire && wstrb_ff) begin
            case (waddr_ff[4:0])
                `OVS_OFS_INT_EN_RISE: en_rise_ff <= wdata_ff;
                `OVS_OFS_INT_EN_FALL: en_fall_ff <= wdata_ff;
                `OVS_OFS_OTG_CTRL:    otg_ff     <= wdata_ff;
                `OVS_OFS_VBUS_IND:    ind_ff     <= wdata_ff;
                `OVS_OFS_IO_PWR:      iopwr_ff   <= wdata_ff;
                `OVS_OFS_CARKIT_CTRL: carkit_ff  <= wdata_ff;
                default: ;  // Read-only status or unmapped, answered with SLVERR
            endcase
        end
    end

    // ========================================================
    // Vbus comparator gating and indicator select
    logic cmp_en;       // Comparator powered
    logic vbus_gated;   // Comparator level seen by software
    logic nxt_rxcmd;    // Next RXCMD vbus-valid bit
    logic ext_ind;      // External indicator level

    // Either edge enable keeps the comparator alive
    assign cmp_en = en_rise_ff[`OVS_BIT_VBUS_VALID]
                  | en_fall_ff[`OVS_BIT_VBUS_VALID];
    // Disabled comparator reads as zero
    assign vbus_gated = vbus_raw & cmp_en;
    // No external pin: indicator held high
    assign ext_ind = `OVS_EXT_INDICATOR;

    // Source mux for the RXCMD vbus-valid bit
    always_comb begin
        if (!ind_ff[`OVS_BIT_USE_EXT]) begin
            nxt_rxcmd = vbus_gated;
        end else if (ind_ff[`OVS_BIT_PASS_THRU]) begin
            nxt_rxcmd = ext_ind ^ ind_ff[`OVS_BIT_COMPLEMENT];
        end else begin
            // Qualifier mode: complement forces zero
            nxt_rxcmd = vbus_gated
                      & (ext_ind ^ ind_ff[`OVS_BIT_COMPLEMENT]);
        end
    end

    // ========================================================
    // UART regulator level, loaded on mode entry
    logic       uart_mode;      // Software selects UART mode
    logic       uart_prev_ff;   // Mode last cycle, for entry edge
    logic [1:0] level_ff;       // Level applied to regulator

    assign uart_mode = iopwr_ff[`OVS_BIT_UART_MODE];

    // Level taken only at entry; later field edits wait
    // for the next entry so the rail does not jump mid-session
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uart_prev_ff <= 1'b0;
            level_ff     <= `OVS_RST_LEVEL;
        end else begin
            uart_prev_ff <= uart_mode;
            if (uart_mode && !uart_prev_ff) begin
                level_ff <= iopwr_ff[`OVS_BIT_LVL_HI:`OVS_BIT_LVL_LO];
            end
        end
    end

    // ========================================================
    // Pull-up and switch decoding
    logic nxt_dp_pu;    // Next D+ charger pull-up
    logic nxt_dm_pu;    // Next D- charger pull-up
    logic nxt_dp_sw;    // Next D+ audio switch
    logic nxt_dm_sw;    // Next D- audio switch
    logic force_sw;     // Supply or reset forces switches on

    // Reset pin low holds both pull-ups off
    assign nxt_dp_pu = rst_pin & iopwr_ff[`OVS_BIT_DP_PULLUP];
    assign nxt_dm_pu = rst_pin & iopwr_ff[`OVS_BIT_DM_PULLUP];

    // Pass-through when the core is unpowered or held
    assign force_sw  = !core_ok || !rst_pin;
    assign nxt_dp_sw = force_sw | carkit_ff[`OVS_BIT_SPK_LEFT];
    assign nxt_dm_sw = force_sw | carkit_ff[`OVS_BIT_SPK_RIGHT]
                     | carkit_ff[`OVS_BIT_MIC];

    // ========================================================
    // Output flops: one edge after the register write
    logic cmp_en_ff;    // Comparator enable out
    logic rxcmd_ff;     // RXCMD vbus-valid out
    logic dis_ff;       // Discharge pull-down out
    logic chg_ff;       // Charge pull-up out
    logic dp_pu_ff;     // D+ pull-up out
    logic dm_pu_ff;     // D- pull-up out
    logic dp_sw_ff;     // D+ switch out
    logic dm_sw_ff;     // D- switch out
    logic se_rx_ff;     // Single-ended receivers out

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp_en_ff <= 1'b0;
            rxcmd_ff  <= 1'b0;
            dis_ff    <= 1'b0;
            chg_ff    <= 1'b0;
            dp_pu_ff  <= 1'b0;
            dm_pu_ff  <= 1'b0;
            dp_sw_ff  <= 1'b0;
            dm_sw_ff  <= 1'b0;
            se_rx_ff  <= 1'b1;
        end else begin
            cmp_en_ff <= cmp_en;
            rxcmd_ff  <= nxt_rxcmd;
            dis_ff    <= otg_ff[`OVS_BIT_DISCHARGE];
            chg_ff    <= otg_ff[`OVS_BIT_CHARGE];
            dp_pu_ff  <= nxt_dp_pu;
            dm_pu_ff  <= nxt_dm_pu;
            dp_sw_ff  <= nxt_dp_sw;
            dm_sw_ff  <= nxt_dm_sw;
            se_rx_ff  <= !(nxt_dp_sw || nxt_dm_sw);
        end
    end

    assign vbus_comparator_enable       = cmp_en_ff;
    assign rxcmd_vbus_valid             = rxcmd_ff;
    assign bus_discharge_enable         = dis_ff;
    assign bus_charge_enable            = chg_ff;
    assign uart_regulator_active        = uart_prev_ff;
    assign uart_regulator_level         = level_ff;
    assign linestate_drive_enable       = !uart_prev_ff;
    assign dplus_charger_pullup_enable  = dp_pu_ff;
    assign dminus_charger_pullup_enable = dm_pu_ff;
    assign dplus_audio_switch_on        = dp_sw_ff;
    assign dminus_audio_switch_on       = dm_sw_ff;
    assign se_receiver_enable           = se_rx_ff;

    // ========================================================
    // Read channel: one cycle from address to data
    logic         rvalid_ff;    // Read data pending
    logic [31:0]  rdata_ff;     // Read data
    ovs_resp_type rresp_ff;     // Read response
    logic [31:0]  rd_word;      // Decoded word
    logic         rd_known;     // Address is mapped

    assign s_axi_arready = !rvalid_ff;

    // Read decode; status word shows live levels
    always_comb begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case (s_axi_araddr[4:0])
            `OVS_OFS_INT_EN_RISE: rd_word[7:0] = en_rise_ff;
            `OVS_OFS_INT_EN_FALL: rd_word[7:0] = en_fall_ff;
            `OVS_OFS_INT_STATUS: begin
                rd_word[`OVS_BIT_VBUS_VALID] = vbus_gated;
                rd_word[`OVS_BIT_SESS_VALID] = sess_raw;
            end
            `OVS_OFS_OTG_CTRL:    rd_word[7:0] = otg_ff;
            `OVS_OFS_VBUS_IND:    rd_word[7:0] = ind_ff;
            `OVS_OFS_IO_PWR:      rd_word[7:0] = iopwr_ff;
            `OVS_OFS_CARKIT_CTRL: rd_word[7:0] = carkit_ff;
            `OVS_OFS_PIN_STATUS: begin
                rd_word[0] = dp_sw_ff;
                rd_word[1] = dm_sw_ff;
                rd_word[2] = se_rx_ff;
                rd_word[3] = rxcmd_ff;
                rd_word[4] = rst_pin;
                rd_word[5] = core_ok;
            end
            default: rd_known = 1'b0;
        endcase
    end

    // Hold data until the master takes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= OVS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_word;
            rresp_ff  <= rd_known ? OVS_RESP_OKAY : OVS_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_otg_write(int b);
        wr_fire && wstrb_ff && waddr_ff[4:0] == `OVS_OFS_OTG_CTRL
            && wdata_ff[b];
    endsequence

    sequence s_status_read;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr[4:0] == `OVS_OFS_INT_STATUS && !cmp_en;
    endsequence

    chk_comp_gate_off: assert property (
        !en_rise_ff[1] && !en_fall_ff[1] |=> !vbus_comparator_enable)
        else $error("comparator enabled with both edge bits clear");

    chk_status_reads_zero: assert property (
        s_status_read |=> s_axi_rvalid && !s_axi_rdata[1])
        else $error("status bit 1 set while comparator disabled");

    chk_internal_source: assert property (
        !ind_ff[0] |=> rxcmd_vbus_valid == $past(vbus_gated))
        else $error("rxcmd not from internal comparator");

    chk_ext_fixed_value: assert property (
        ind_ff[0] && ind_ff[1] |=> rxcmd_vbus_valid == !$past(ind_ff[2]))
        else $error("pass-through value wrong");

    chk_discharge_write: assert property (
        s_otg_write(3) |=> ##1 bus_discharge_enable)
        else $error("discharge not applied after write");

    chk_charge_write: assert property (
        s_otg_write(4) |=> ##1 bus_charge_enable)
        else $error("charge not applied after write");

    chk_uart_level_load: assert property (
        uart_mode && !uart_prev_ff |=> uart_regulator_level
            == $past(iopwr_ff[3:2]) && uart_regulator_active)
        else $error("regulator level not loaded on uart entry");

    chk_uart_linestate: assert property (
        uart_mode |=> uart_regulator_active && !linestate_drive_enable)
        else $error("line state driven in uart mode");

    chk_pullup_reset_pin: assert property (
        !rst_pin |=> !dplus_charger_pullup_enable
            && !dminus_charger_pullup_enable)
        else $error("charger pull-up on while reset pin low");

    // Output flops are still held at the edge that releases reset
    chk_switch_forced_on: assert property (
        rstn && force_sw |=> dplus_audio_switch_on && dminus_audio_switch_on)
        else $error("audio switches not forced on");

    chk_se_receiver_off: assert property (
        dplus_audio_switch_on || dminus_audio_switch_on
            |-> !se_receiver_enable)
        else $error("single-ended receivers on with switch on");

endmodule

`default_nettype wire

// ==== ovs_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Far-side model: board levels that the block sees
module ovs_link_model (
    // Clock
    input  wire logic       clk,
    // Wanted levels: vbus cmp, session cmp, reset pin, core supply
    input  wire logic [3:0] req,
    // Levels toward the block, known from time zero
    output var logic  [3:0] pins = 4'h0
);
    // Link starts on session valid, never on vbus valid
    // No supply switch pin on the block; link owns it
    always @(posedge clk) begin
        pins <= req;
    end
endmodule

`default_nettype wire

// ==== test_otg_vbus_and_switch_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ovs_defs.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module test_otg_vbus_and_switch_control;
    import ovs_pkg::*;
    // ========================================================
    // Bus, pin and bookkeeping signals
    logic         clk = 1'h0, rstn = 1'h0;
    logic [4:0]   awaddr = 5'h00, araddr = 5'h00;
    logic [31:0]  wdata = 32'h0, rdata, rd;
    logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic         arvalid = 1'h0, rready = 1'h0;
    logic         awready, wready, bvalid, arready, rvalid;
    ovs_resp_type bresp, rresp;
    logic [3:0]   req = 4'hC, pins;
    logic         cmp_en, rx_vld, dis_en, chg_en, uart_on, ls_en;
    logic [1:0]   uart_lvl;
    logic         dp_pu, dm_pu, dp_sw, dm_sw, se_en;
    int           miscompares = 0, n_checks = 0, cycles = 0;

    // ========================================================
    // Design and board model
    ovs_ctrl u_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus_voltage_valid_comparator(pins[0]),
        .session_valid_comparator(pins[1]), .chip_reset_n(pins[2]),
        .core_supply_present(pins[3]), .vbus_comparator_enable(cmp_en),
        .rxcmd_vbus_valid(rx_vld), .bus_discharge_enable(dis_en),
        .bus_charge_enable(chg_en), .uart_regulator_active(uart_on),
        .uart_regulator_level(uart_lvl), .linestate_drive_enable(ls_en),
        .dplus_charger_pullup_enable(dp_pu),
        .dminus_charger_pullup_enable(dm_pu),
        .dplus_audio_switch_on(dp_sw), .dminus_audio_switch_on(dm_sw),
        .se_receiver_enable(se_en));
    ovs_link_model u_link (.clk(clk), .req(req), .pins(pins));

    // ========================================================
    // Clock and hang guard; 20000 cycles is ample for this run
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    // ========================================================
    // Shared helpers
    task check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Write one byte; response code checked; pins given time to follow
    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [1:0] r = 2'h0);
        awaddr <= a; wdata <= {24'h0, d}; bready <= 1'h1;
        awvalid <= 1'h1; wvalid <= 1'h1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        `CHK(bresp, r);
        bready <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rdr(input logic [4:0] a);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rd = rdata;
        `CHK(rresp, 2'h0);
        rready <= 1'h0;
        @(posedge clk);
    endtask
    // Pin changes pass the model flop and the two-flop synchroniser
    task pin(input logic [3:0] v);
        req <= v;
        repeat (6) @(posedge clk);
    endtask

    // ========================================================
    // Scenarios
    task t_reset();
        rdr(`OVS_OFS_OTG_CTRL);   `CHK(rd, 32'h0);
        rdr(`OVS_OFS_CARKIT_CTRL); `CHK(rd, 32'h0);
        rdr(`OVS_OFS_VBUS_IND);   `CHK(rd, 32'h0);
        `CHK({dp_sw, dm_sw, se_en, dis_en, chg_en, dp_pu}, 6'h08);
        wr(`OVS_OFS_PIN_STATUS, 8'h01, 2'h2);
    endtask
    task t_gate();
        pin(4'hF);
        rdr(`OVS_OFS_INT_STATUS); `CHK(rd[2:1], 2'h2);
        `CHK(cmp_en, 1'h0);
        wr(`OVS_OFS_INT_EN_FALL, 8'h02); `CHK(cmp_en, 1'h1);
        rdr(`OVS_OFS_INT_STATUS); `CHK(rd[2:1], 2'h3);
        wr(`OVS_OFS_INT_EN_FALL, 8'h00);
        `CHK(cmp_en, 1'h0);
        wr(`OVS_OFS_INT_EN_RISE, 8'h02); `CHK(cmp_en, 1'h1);
    endtask
    // Every select code against both comparator levels
    task t_ind();
        logic [3:0] i;
        logic       exp_vld;
        for (int n = 0; n < 16; n++) begin
            i = 4'(n);
            pin({3'h6, i[3]});
            wr(`OVS_OFS_VBUS_IND, {5'h0, i[2:0]});
            exp_vld = !i[0] ? i[3] : i[1] ? !i[2] : !i[2] && i[3];
            `CHK(rx_vld, exp_vld);
        end
        wr(`OVS_OFS_VBUS_IND, 8'h06);
        `CHK(rx_vld, 1'h1);
    endtask
    task t_otg();
        for (int n = 0; n < 4; n++) begin
            wr(`OVS_OFS_OTG_CTRL, 8'(n << 3));
            `CHK(dis_en, n[0]);
            `CHK(chg_en, n[1]);
        end
    endtask
    task t_pull_sw();
        wr(`OVS_OFS_IO_PWR, 8'h01); `CHK({dp_pu, dm_pu}, 2'h2);
        wr(`OVS_OFS_IO_PWR, 8'h02); `CHK({dp_pu, dm_pu}, 2'h1);
        pin(4'h8);
        `CHK({dp_pu, dm_pu, dp_sw, dm_sw}, 4'h3);
        `CHK(se_en, 1'h0);
        pin(4'h4); `CHK({dp_sw, dm_sw}, 2'h3);
        pin(4'hC);
        for (int n = 0; n < 8; n++) begin
            wr(`OVS_OFS_CARKIT_CTRL, 8'(n));
            `CHK({dp_sw, dm_sw}, {n[0], n[1] | n[2]});
            `CHK(se_en, !(n[0] | n[1] | n[2]));
        end
    endtask
    task t_uart();
        wr(`OVS_OFS_IO_PWR, 8'h08); `CHK({uart_on, ls_en}, 2'h1);
        wr(`OVS_OFS_IO_PWR, 8'h18); `CHK(uart_lvl, 2'h2);
        `CHK({uart_on, ls_en}, 2'h2);
    endtask
    // Second reset in mid-run must clear the OTG, carkit and IO power bits and their outputs
    task t_rerun();
        wr(`OVS_OFS_OTG_CTRL, 8'h18);
        wr(`OVS_OFS_CARKIT_CTRL, 8'h07);
        wr(`OVS_OFS_IO_PWR, 8'h1B);
        `CHK({dis_en, chg_en, dp_pu, dm_pu, dp_sw, dm_sw}, 6'h3F);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        pin(4'hC);
        rdr(`OVS_OFS_OTG_CTRL);
        `CHK(rd, 32'h0);
        rdr(`OVS_OFS_CARKIT_CTRL);
        `CHK(rd, 32'h0);
        rdr(`OVS_OFS_IO_PWR);
        `CHK(rd, 32'h0);
        `CHK({dis_en, chg_en, dp_pu, dm_pu, dp_sw, dm_sw}, 6'h00);
        `CHK({uart_on, uart_lvl, se_en}, 4'h1);
    endtask

    // ========================================================
    // Verdict and the single end of the run
    task complete_run();
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        pin(4'hC);
        t_reset();
        t_gate();
        t_ind();
        t_otg();
        t_pull_sw();
        t_uart();
        t_rerun();
        complete_run();
    end
endmodule

`default_nettype wire
